// ==== verilog/afe_consts.svh ====
// afe_consts.svh: offsets, field positions, resets
// assumes byte-wide register port, 8-bit index
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH
// ****************************************
// register offsets
// ****************************************
`define AFE_A_LINE 8'h00
`define AFE_A_SDET 8'h01
`define AFE_A_BDIS 8'h02
`define AFE_A_MODE 8'h03
`define AFE_A_ACRST 8'h04
`define AFE_A_OFF0 8'h05
`define AFE_A_OFFALL 8'h08
`define AFE_A_GAIN0 8'h09
`define AFE_A_GAINALL 8'h0C
// ****************************************
// field positions
// ****************************************
`define AFE_F_LBL 0
`define AFE_F_ACYC 1
`define AFE_F_FME 2
`define AFE_F_ICLMP 3
`define AFE_F_INTM 5:4
`define AFE_F_FM 7:6
`define AFE_F_DETEN 0
`define AFE_F_DLY 3:1
`define AFE_F_POL 4
`define AFE_F_MASK 3:0
`define AFE_F_MONO 0
`define AFE_F_SELECTIVE_POWERDOWN_EN 1
`define AFE_F_CHAN 3:2
// ****************************************
// reset values and forced codes
// ****************************************
`define AFE_RST_BYTE 8'h00
`define AFE_LBL_OFF 4'h6
`define AFE_CHAN_FORCED 2'h0
`endif

// ==== verilog/afe_pkg.sv ====
// afe_pkg: types of the afe register bank
// assumes nothing beyond the compiler
`default_nettype none
package afe_pkg;
  typedef logic [7:0] afe_byte_t;
  typedef logic [2:0] afe_dly_t;
  // colour codes, red first
  typedef enum logic [1:0] {
    AFE_RED, AFE_GREEN, AFE_BLUE, AFE_RSVD
  } afe_colour_e;
endpackage
`default_nettype wire

// ==== verilog/afe_cycle_ctr.sv ====
// afe_cycle_ctr: auto-cycle colour counter
// assumes step and clear are one-cycle pulses
`default_nettype none
module afe_cycle_ctr (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic step_in,
  input wire logic clear_in,
  output afe_pkg::afe_colour_e colour_out
);
  import afe_pkg::*;
  // ****************************************
  // counter
  // ****************************************
  afe_colour_e col_q;
  afe_colour_e col_d;
  // clear wins, blue wraps to red
  assign col_d = clear_in ? AFE_RED :
    !step_in ? col_q :
    (col_q == AFE_RED) ? AFE_GREEN :
    (col_q == AFE_GREEN) ? AFE_BLUE : AFE_RED;
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) col_q <= AFE_RED;
    else col_q <= col_d;
  end
  assign colour_out = col_q;
  property p_wrap;
    @(posedge ref_clk_in) disable iff (rst_in)
    step_in && !clear_in && col_q == AFE_BLUE |=> col_q == AFE_RED;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap");
endmodule // afe_cycle_ctr
`default_nettype wire

// ==== verilog/afe_sample_det.sv ====
// afe_sample_det: sample pin edge detect, delay
// assumes pin may be asynchronous to the clock
`default_nettype none
module afe_sample_det #(
  parameter int DW = 3
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic rise_in,
  input wire logic [DW-1:0] dly_in,
  output logic pulse_out
);
  import afe_pkg::*;
  // ****************************************
  // synchroniser and edge
  // ****************************************
  logic s1_q, s2_q, s3_q, pulse_q, edge_w;
  logic [DW-1:0] cnt_q;
  // polarity picks the edge
  assign edge_w = rise_in ? (s2_q && !s3_q) : (!s2_q && s3_q);
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      {s1_q, s2_q, s3_q} <= 3'h0;
    end else begin
      {s1_q, s2_q, s3_q} <= {pin_in, s1_q, s2_q};
    end
  end
  // ****************************************
  // delay counter
  // ****************************************
  // count from the edge cycle, pulse at end
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      pulse_q <= 1'b0;
    end else if (edge_w) begin
      cnt_q <= dly_in;
      pulse_q <= (dly_in == '0);
    end else begin
      cnt_q <= (cnt_q == '0) ? cnt_q : cnt_q - 1'b1;
      pulse_q <= (cnt_q == DW'(1));
    end
  end
  assign pulse_out = pulse_q;
  property p_two;
    @(posedge ref_clk_in) disable iff (rst_in)
    (edge_w && dly_in == 3'h2) ##1 (!edge_w)[*2] |=> pulse_q;
  endproperty
  a_two: assert property (p_two) else $error("delay 2 late");
endmodule // afe_sample_det
`default_nettype wire

// ==== verilog/afe_mode_gain_regs.sv ====
// afe_mode_gain_regs: afe mode and gain bank
// assumes a synchronous byte register port
// and synchronous sample and clamp pins
//
// Operation
// - setup bit 0 selects line-by-line
// - line-by-line forces mono, red channel
// - line-by-line disables green, blue blocks
// - clamp pin clamps or steps cycle
// - auto-cycle takes clamp from register bit
// - force mux drives input mux only
// - internal colour in bits 5:4
// - forced input in bits 7:6
// - detect bit picks raw or pulse
// - pulse delayed by delay field cycles
// - polarity bit selects detected edge
// - mask bits disable red, green, blue, adc
// - three 8-bit offsets, reset zero
// - offset broadcast loads all three
// - three 8-bit gains, reset zero
// - gain broadcast loads all three
// - mask acts only with selective powerdown
// - cycle reset write returns to red
// - mono channel 00 red, 10 blue
`include "afe_consts.svh"
`default_nettype none
module afe_mode_gain_regs (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire afe_pkg::afe_byte_t addr_in,
  input wire afe_pkg::afe_byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic sample_pulse_pin_in,
  input wire logic clamp_or_cycle_pin_in,
  output afe_pkg::afe_byte_t rdata_out,
  output logic mono_out,
  output logic [1:0] mono_channel_sel_out,
  output logic [1:0] input_sel_out,
  output logic [1:0] colour_sel_out,
  output logic clamp_en_out,
  output logic timing_sample_out,
  output logic [3:0] block_disable_out,
  output afe_pkg::afe_byte_t sel_offset_out,
  output afe_pkg::afe_byte_t sel_gain_out
);
  import afe_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  afe_byte_t line_q;
  afe_byte_t sdet_q;
  afe_byte_t bdis_q;
  afe_byte_t mode_q;
  afe_byte_t off_q [3];
  afe_byte_t gain_q [3];
  afe_byte_t rdata_q;
  logic clp_q;
  logic mono_q;
  logic [1:0] chan_q;
  logic [1:0] insel_q;
  logic [1:0] colsel_q;
  logic clamp_q;
  logic tsmp_q;
  logic [3:0] bdis_out_q;
  afe_byte_t seloff_q;
  afe_byte_t selgain_q;

  // ****************************************
  // address decode
  // ****************************************
  logic wr_line, wr_sdet, wr_bdis, wr_mode;
  logic wr_acrst, wr_offall, wr_gainall;
  logic [1:0] idx_off, idx_gain;
  logic hit_off, hit_gain;
  afe_byte_t rd_d;

  // one strobe per location
  assign wr_line = wr_in && addr_in == `AFE_A_LINE;
  assign wr_sdet = wr_in && addr_in == `AFE_A_SDET;
  assign wr_bdis = wr_in && addr_in == `AFE_A_BDIS;
  assign wr_mode = wr_in && addr_in == `AFE_A_MODE;
  assign wr_acrst = wr_in && addr_in == `AFE_A_ACRST;
  assign wr_offall = wr_in && addr_in == `AFE_A_OFFALL;
  assign wr_gainall = wr_in && addr_in == `AFE_A_GAINALL;
  // channel index inside each group of three
  assign idx_off = 2'(addr_in - `AFE_A_OFF0);
  assign idx_gain = 2'(addr_in - `AFE_A_GAIN0);
  assign hit_off = addr_in >= `AFE_A_OFF0 &&
    addr_in < `AFE_A_OFFALL;
  assign hit_gain = addr_in >= `AFE_A_GAIN0 &&
    addr_in < `AFE_A_GAINALL;

  // read mux, write-only and unmapped read zero
  assign rd_d = !rd_in ? `AFE_RST_BYTE :
    addr_in == `AFE_A_LINE ? line_q :
    addr_in == `AFE_A_SDET ? sdet_q :
    addr_in == `AFE_A_BDIS ? bdis_q :
    addr_in == `AFE_A_MODE ? mode_q :
    hit_off ? off_q[idx_off] :
    hit_gain ? gain_q[idx_gain] :
    `AFE_RST_BYTE;

  // ****************************************
  // setup register writes
  // ****************************************
  // all setup fields reset to zero
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      line_q <= `AFE_RST_BYTE;
      sdet_q <= `AFE_RST_BYTE;
      bdis_q <= `AFE_RST_BYTE;
      mode_q <= `AFE_RST_BYTE;
      rdata_q <= `AFE_RST_BYTE;
    end else begin
      if (wr_line) line_q <= wdata_in;
      if (wr_sdet) sdet_q <= wdata_in;
      if (wr_bdis) bdis_q <= wdata_in;
      if (wr_mode) mode_q <= wdata_in;
      rdata_q <= rd_d;
    end
  end

  // ****************************************
  // offset and gain codes
  // ****************************************
  // broadcast writes load every channel
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < 3; i++) begin
        off_q[i] <= `AFE_RST_BYTE;
        gain_q[i] <= `AFE_RST_BYTE;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_offall || (wr_in && hit_off && idx_off == 2'(i))) begin
          off_q[i] <= wdata_in;
        end
        if (wr_gainall || (wr_in && hit_gain && idx_gain == 2'(i))) begin
          gain_q[i] <= wdata_in;
        end
      end
    end
  end

  // ****************************************
  // mode decode
  // ****************************************
  logic lbl, acyc, force_input_mux_en, selective_powerdown_en, step, clp_rise;
  logic [1:0] chan_eff, cyc_col, col_d, in_d;
  logic [3:0] dis_d;
  logic tsmp_d, det_pulse, clamp_d;
  afe_colour_e cyc_e;

  assign lbl = line_q[`AFE_F_LBL];
  assign acyc = lbl && line_q[`AFE_F_ACYC];
  assign force_input_mux_en = lbl && line_q[`AFE_F_FME];
  assign selective_powerdown_en = mode_q[`AFE_F_SELECTIVE_POWERDOWN_EN];
  assign cyc_col = cyc_e;
  // line-by-line forces mono and red channel
  assign chan_eff = lbl ? `AFE_CHAN_FORCED : mode_q[`AFE_F_CHAN];
  // colour for offset and gain mux
  assign col_d = !lbl ? chan_eff :
    acyc ? cyc_col : line_q[`AFE_F_INTM];
  // input mux may be forced apart
  assign in_d = force_input_mux_en ? line_q[`AFE_F_FM] : col_d;
  // clamp from pin unless auto-cycling
  assign clamp_d = acyc ? line_q[`AFE_F_ICLMP] : clp_q;
  // cycle steps on clamp pin rising edge
  assign clp_rise = clamp_or_cycle_pin_in && !clp_q;
  assign step = acyc && clp_rise;
  // mask gated, green and blue off in lbl
  assign dis_d = (selective_powerdown_en ? bdis_q[`AFE_F_MASK] : 4'h0) |
    (lbl ? `AFE_LBL_OFF : 4'h0);
  // raw pin or detected pulse
  assign tsmp_d = sdet_q[`AFE_F_DETEN] ? det_pulse : sample_pulse_pin_in;

  // ****************************************
  // leaf blocks
  // ****************************************
  afe_cycle_ctr u_cyc (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .step_in(step),
    .clear_in(wr_acrst),
    .colour_out(cyc_e)
  );

  afe_sample_det #(.DW(3)) u_det (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .pin_in(sample_pulse_pin_in),
    .rise_in(sdet_q[`AFE_F_POL]),
    .dly_in(sdet_q[`AFE_F_DLY]),
    .pulse_out(det_pulse)
  );

  // ****************************************
  // output flops
  // ****************************************
  // every output leaves from a flop
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clp_q <= 1'b0;
      mono_q <= 1'b0;
      chan_q <= 2'h0;
      insel_q <= 2'h0;
      colsel_q <= 2'h0;
      clamp_q <= 1'b0;
      tsmp_q <= 1'b0;
      bdis_out_q <= 4'h0;
      seloff_q <= `AFE_RST_BYTE;
      selgain_q <= `AFE_RST_BYTE;
    end else begin
      clp_q <= clamp_or_cycle_pin_in;
      mono_q <= lbl || mode_q[`AFE_F_MONO];
      chan_q <= chan_eff;
      insel_q <= in_d;
      colsel_q <= col_d;
      clamp_q <= clamp_d;
      tsmp_q <= tsmp_d;
      bdis_out_q <= dis_d;
      seloff_q <= (col_d == 2'h3) ? `AFE_RST_BYTE : off_q[col_d];
      selgain_q <= (col_d == 2'h3) ? `AFE_RST_BYTE : gain_q[col_d];
    end
  end

  assign rdata_out = rdata_q;
  assign mono_out = mono_q;
  assign mono_channel_sel_out = chan_q;
  assign input_sel_out = insel_q;
  assign colour_sel_out = colsel_q;
  assign clamp_en_out = clamp_q;
  assign timing_sample_out = tsmp_q;
  assign block_disable_out = bdis_out_q;
  assign sel_offset_out = seloff_q;
  assign sel_gain_out = selgain_q;

  // ****************************************
  // checks
  // ****************************************
  property p_mono;
    @(posedge ref_clk_in) disable iff (rst_in)
    lbl |=> mono_q && chan_q == 2'h0;
  endproperty
  a_mono: assert property (p_mono) else $error("lbl not mono");

  property p_gb_off;
    @(posedge ref_clk_in) disable iff (rst_in)
    lbl |=> bdis_out_q[2:1] == 2'h3;
  endproperty
  a_gb_off: assert property (p_gb_off) else $error("green/blue on");

  property p_iclamp;
    @(posedge ref_clk_in) disable iff (rst_in)
    acyc |=> clamp_q == $past(line_q[3]);
  endproperty
  a_iclamp: assert property (p_iclamp) else $error("clamp src");

  property p_force;
    @(posedge ref_clk_in) disable iff (rst_in)
    force_input_mux_en |=> insel_q == $past(line_q[7:6]);
  endproperty
  a_force: assert property (p_force) else $error("force mux");

  property p_raw;
    @(posedge ref_clk_in) disable iff (rst_in)
    !sdet_q[0] |=> tsmp_q == $past(sample_pulse_pin_in);
  endproperty
  a_raw: assert property (p_raw) else $error("raw sample");

  property p_gate;
    @(posedge ref_clk_in) disable iff (rst_in)
    !selective_powerdown_en && !lbl |=> bdis_out_q == 4'h0;
  endproperty
  a_gate: assert property (p_gate) else $error("mask ungated");

  property p_offall;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_offall |=> off_q[0] == $past(wdata_in) &&
      off_q[1] == $past(wdata_in) && off_q[2] == $past(wdata_in);
  endproperty
  a_offall: assert property (p_offall) else $error("offset bcast");

  property p_gainall;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_gainall |=> gain_q[0] == $past(wdata_in) &&
      gain_q[1] == $past(wdata_in) && gain_q[2] == $past(wdata_in);
  endproperty
  a_gainall: assert property (p_gainall) else $error("gain bcast");

  property p_acrst;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_acrst |=> cyc_e == AFE_RED ##1 colsel_q == 2'h0 || !$past(acyc);
  endproperty
  a_acrst: assert property (p_acrst) else $error("cycle reset");

  property p_chan_ext;
    @(posedge ref_clk_in) disable iff (rst_in)
    !lbl |=> colsel_q == $past(mode_q[`AFE_F_CHAN]);
  endproperty
  a_chan_ext: assert property (p_chan_ext) else $error("mono channel colour");

  property p_intm;
    @(posedge ref_clk_in) disable iff (rst_in)
    lbl && !acyc |=> colsel_q == $past(line_q[`AFE_F_INTM]);
  endproperty
  a_intm: assert property (p_intm) else $error("internal colour");

  property p_cyc_sel;
    @(posedge ref_clk_in) disable iff (rst_in)
    acyc |=> colsel_q == $past(cyc_col);
  endproperty
  a_cyc_sel: assert property (p_cyc_sel) else $error("cycle colour");

  property p_noforce;
    @(posedge ref_clk_in) disable iff (rst_in)
    !force_input_mux_en |=> insel_q == colsel_q;
  endproperty
  a_noforce: assert property (p_noforce) else $error("input forced");

  property p_mask;
    @(posedge ref_clk_in) disable iff (rst_in)
    selective_powerdown_en && !lbl |=> bdis_out_q == $past(bdis_q[`AFE_F_MASK]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask bits");

  property p_red_codes;
    @(posedge ref_clk_in) disable iff (rst_in)
    col_d == 2'h0 |=> seloff_q == $past(off_q[0]) && selgain_q == $past(gain_q[0]);
  endproperty
  a_red_codes: assert property (p_red_codes) else $error("red codes");

  property p_rsvd_codes;
    @(posedge ref_clk_in) disable iff (rst_in)
    col_d == 2'h3 |=> seloff_q == 8'h00 && selgain_q == 8'h00;
  endproperty
  a_rsvd_codes: assert property (p_rsvd_codes) else $error("reserved codes");

  property p_cyc_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !acyc && !wr_acrst |=> cyc_e == $past(cyc_e);
  endproperty
  a_cyc_hold: assert property (p_cyc_hold) else $error("cycle moved");

  property p_cyc_step;
    @(posedge ref_clk_in) disable iff (rst_in)
    step && !wr_acrst |=> cyc_e != $past(cyc_e);
  endproperty
  a_cyc_step: assert property (p_cyc_step) else $error("cycle stuck");

  property p_pin_clamp;
    @(posedge ref_clk_in) disable iff (rst_in)
    !acyc |=> clamp_q == $past(clp_q);
  endproperty
  a_pin_clamp: assert property (p_pin_clamp) else $error("pin clamp");
endmodule // afe_mode_gain_regs
`default_nettype wire

// ==== test/afe_scan_model.sv ====
// afe_scan_model: scanner controller driving sample and clamp pins
// assumes the bench calls its tasks from one process at a time
`default_nettype none
module afe_scan_model (
  input wire logic ref_clk_in,
  output logic sample_pulse_pin_out,
  output logic clamp_or_cycle_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // both pins idle low
  initial begin
    sample_pulse_pin_out = 1'b0;
    clamp_or_cycle_pin_out = 1'b0;
  end
  // sample pin level, changed just after an edge
  task automatic set_sample(input logic v);
    @(posedge ref_clk_in);
    sample_pulse_pin_out <= v;
  endtask
  // clamp level when the pin serves reset level clamping
  task automatic set_clamp(input logic v);
    @(posedge ref_clk_in);
    clamp_or_cycle_pin_out <= v;
  endtask
  // one-cycle pulse stepping the colour auto-cycle
  task automatic step;
    @(posedge ref_clk_in);
    clamp_or_cycle_pin_out <= 1'b1;
    @(posedge ref_clk_in);
    clamp_or_cycle_pin_out <= 1'b0;
  endtask
endmodule // afe_scan_model
`default_nettype wire

// ==== test/afe_mode_gain_regs_test.sv ====
// afe_mode_gain_regs_test: self-checking bench of the mode and gain bank
// assumes afe_pkg and afe_scan_model are compiled before it
`default_nettype none
module afe_mode_gain_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import afe_pkg::*;
  logic ref_clk_in, rst_in, wr_in, rd_in, smp, clp;
  afe_byte_t addr_in, wdata_in, rdata_out, sel_offset_out, sel_gain_out;
  logic mono_out, clamp_en_out, timing_sample_out;
  logic [1:0] mono_channel_sel_out, input_sel_out, colour_sel_out;
  logic [3:0] block_disable_out;
  int n_mismatch, n_checks;
  afe_mode_gain_regs u_dut (.ref_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .sample_pulse_pin_in(smp), .clamp_or_cycle_pin_in(clp), .rdata_out, .mono_out,
    .mono_channel_sel_out, .input_sel_out, .colour_sel_out, .clamp_en_out,
    .timing_sample_out, .block_disable_out, .sel_offset_out, .sel_gain_out);
  afe_scan_model u_scan (.ref_clk_in, .sample_pulse_pin_out(smp), .clamp_or_cycle_pin_out(clp));
  // ****************************************
  // bus, compare and closing tasks
  // ****************************************
  task automatic chk(input string s, input afe_byte_t e, input afe_byte_t g);
    n_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", s, e, g);
      n_mismatch++;
    end
  endtask
  task automatic wr(input afe_byte_t a, input afe_byte_t d);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  // read data stand only in the cycle after the read edge
  task automatic rd(input afe_byte_t a, input afe_byte_t e);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    chk("rdata", e, rdata_out);
  endtask
  // lets register and output stages land
  task automatic settle;
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    for (int i = 0; i < 13; i++) rd(8'(i), 8'h00);
    rd(8'h20, 8'h00);
    chk("disable", 8'h00, 8'(block_disable_out));
    $display("test reset done");
  endtask
  task automatic t_regs;
    for (int i = 0; i < 12; i++) if (i != 4 && i != 8) wr(8'(i), 8'(i * 37 + 5));
    for (int i = 0; i < 12; i++) if (i != 4 && i != 8) rd(8'(i), 8'(i * 37 + 5));
    wr(8'h08, 8'h5A);
    wr(8'h0C, 8'hA5);
    for (int i = 5; i < 8; i++) rd(8'(i), 8'h5A);
    for (int i = 9; i < 12; i++) rd(8'(i), 8'hA5);
    rd(8'h08, 8'h00);
    rd(8'h0C, 8'h00);
    @(negedge ref_clk_in);
    chk("rdata idle", 8'h00, rdata_out);
    $display("test regs done");
  endtask
  task automatic t_mono;
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h09);
    wr(8'h07, 8'h3C);
    wr(8'h0B, 8'hC3);
    settle;
    chk("mono", 8'h01, 8'(mono_out));
    chk("chan", 8'h02, 8'(mono_channel_sel_out));
    chk("colour", 8'h02, 8'(colour_sel_out));
    chk("offset", 8'h3C, sel_offset_out);
    chk("gain", 8'hC3, sel_gain_out);
    wr(8'h03, 8'h0C);
    wr(8'h00, 8'h11);
    wr(8'h06, 8'h77);
    settle;
    chk("mono", 8'h01, 8'(mono_out));
    chk("chan", 8'h00, 8'(mono_channel_sel_out));
    chk("colour", 8'h01, 8'(colour_sel_out));
    chk("offset", 8'h77, sel_offset_out);
    chk("disable", 8'h06, 8'(block_disable_out));
    wr(8'h00, 8'h00);
    settle;
    chk("mono", 8'h00, 8'(mono_out));
    chk("chan", 8'h03, 8'(mono_channel_sel_out));
    chk("disable", 8'h00, 8'(block_disable_out));
    $display("test mono done");
  endtask
  task automatic t_mask;
    wr(8'h02, 8'h0F);
    wr(8'h03, 8'h00);
    settle;
    chk("disable", 8'h00, 8'(block_disable_out));
    wr(8'h03, 8'h02);
    settle;
    chk("disable", 8'h0F, 8'(block_disable_out));
    wr(8'h02, 8'h01);
    wr(8'h00, 8'h01);
    settle;
    chk("disable", 8'h07, 8'(block_disable_out));
    $display("test mask done");
  endtask
  task automatic t_force;
    wr(8'h03, 8'h08);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, {2'(i), 2'(2 - i), 4'h5});
      settle;
      chk("input", 8'(i), 8'(input_sel_out));
      chk("colour", 8'(2 - i), 8'(colour_sel_out));
    end
    wr(8'h00, 8'h91);
    settle;
    chk("input", 8'h01, 8'(input_sel_out));
    wr(8'h00, 8'h44);
    settle;
    chk("input", 8'h02, 8'(input_sel_out));
    $display("test force done");
  endtask
  task automatic t_cycle;
    wr(8'h00, 8'h03);
    wr(8'h04, 8'h00);
    settle;
    chk("colour", 8'h00, 8'(colour_sel_out));
    chk("clamp", 8'h00, 8'(clamp_en_out));
    for (int i = 1; i < 5; i++) begin
      u_scan.step();
      settle;
      chk("colour", 8'(i % 3), 8'(colour_sel_out));
      chk("input", 8'(i % 3), 8'(input_sel_out));
    end
    wr(8'h04, 8'h00);
    settle;
    chk("colour", 8'h00, 8'(colour_sel_out));
    wr(8'h00, 8'h0B);
    settle;
    chk("clamp", 8'h01, 8'(clamp_en_out));
    wr(8'h00, 8'h01);
    u_scan.set_clamp(1'b1);
    settle;
    chk("clamp", 8'h01, 8'(clamp_en_out));
    u_scan.set_clamp(1'b0);
    settle;
    chk("clamp", 8'h00, 8'(clamp_en_out));
    $display("test cycle done");
  endtask
  task automatic t_sample;
    int n;
    int base;
    int hits;
    int dl[3] = '{0, 3, 7};
    wr(8'h01, 8'h00);
    u_scan.set_sample(1'b1);
    settle;
    chk("sample", 8'h01, 8'(timing_sample_out));
    u_scan.set_sample(1'b0);
    settle;
    chk("sample", 8'h00, 8'(timing_sample_out));
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 3; k++) begin
        wr(8'h01, {3'h0, 1'(p), 3'(dl[k]), 1'b1});
        u_scan.set_sample(1'(p == 0));
        repeat (12) @(posedge ref_clk_in);
        u_scan.set_sample(1'(p));
        n = 0;
        while (timing_sample_out !== 1'b1 && n < 40) begin
          @(negedge ref_clk_in);
          n++;
        end
        if (k == 0) base = n;
        if (k == 0) chk("latency", 8'h05, 8'(base));
        chk("delay", 8'(base + dl[k]), 8'(n));
        @(negedge ref_clk_in);
        chk("width", 8'h00, 8'(timing_sample_out));
        u_scan.set_sample(1'(p == 0));
        hits = 0;
        repeat (20) begin
          @(negedge ref_clk_in);
          hits += int'(timing_sample_out === 1'b1);
        end
        chk("other edge", 8'h00, 8'(hits));
      end
    end
    $display("test sample done");
  endtask
  // ****************************************
  // clock, reset, sequence and watchdog
  // ****************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    rst_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 8'h00;
    n_mismatch = 0;
    n_checks = 0;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset;
    t_regs;
    t_mono;
    t_mask;
    t_force;
    t_cycle;
    t_sample;
    summarize;
  end
  // cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    summarize;
  end
endmodule // afe_mode_gain_regs_test
`default_nettype wire
